// ---- external_data_access_stretch.sv ----
// External data move sequencer with programmable stretch and dual data pointers.
//
// How it works
// - Opcode fetch of four clocks comes first.
// - Next machine cycle drives address and accesses.
// - Stretch field is clock control bits 2-0.
// - Move lasts stretch plus two machine cycles.
// - Stretch affects only the external data move.
// - Stretch cycles freeze the CPU state.
// - Stretch resets to one; zero is fastest.
// - Strobe width 2, then four clocks per step.
// - Pointer select picks primary or secondary pointer.
`timescale 1ns/10ps
`include "xmove_defs.svh"

module external_data_access_stretch (
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // Core-side controls.
    input  wire xmove_pkg::move_req_t req,
    input  wire logic                 ctrl_we,
    input  wire logic [7:0]           ctrl_wdata,
    input  wire logic                 psel_we,
    input  wire logic [7:0]           psel_wdata,
    input  wire logic                 primary_data_pointer_we,
    input  wire logic [15:0]          primary_data_pointer_wdata,
    input  wire logic                 primary_data_pointer_inc,
    input  wire logic [7:0]           ext_data_in,
    // Core-side results.
    output logic                      cpu_hold,
    output logic                      move_done,
    output logic [7:0]                read_data,
    output logic [7:0]                clock_control_reg,
    output logic [7:0]                pointer_select,
    output logic [15:0]               primary_data_pointer,
    output logic [15:0]               secondary_data_pointer,
    // External memory bus.
    output xmove_pkg::ext_bus_t       ext_bus
);
    import xmove_pkg::*;

    move_state_t state;
    logic [1:0]  phase;
    logic [4:0]  strobe_left;
    logic [2:0]  stretch_seen;
    logic        dir_write;
    logic [4:0]  next_strobe_len;
    logic [2:0]  stretch_select;
    logic [15:0] sel_pointer;

    assign stretch_select = clock_control_reg[`STRETCH_MSB:`STRETCH_LSB];
    assign sel_pointer    = pointer_select[0] ? secondary_data_pointer : primary_data_pointer;

    // Strobe width: two clocks at zero, four clocks per step above that.
    // Taken from the value latched at start, so a stretch write during the fetch leaves this move alone.
    always_comb begin
        if (stretch_seen == 3'h0) begin
            next_strobe_len = `STROBE_BASE_ZERO;
        end else begin
            next_strobe_len = {stretch_seen, 2'b00};
        end
    end

    // Clock control register; the stretch field resets to one.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clock_control_reg <= {5'h00, `STRETCH_RESET};
        end else if (ctrl_we) begin
            clock_control_reg <= ctrl_wdata;
        end
    end

    // Pointer select; only bit zero is kept, and it steers loads and increments to one pointer.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pointer_select <= `POINTER_SEL_RESET;
        end else if (psel_we) begin
            pointer_select <= {7'h00, psel_wdata[0]};
        end
    end

    // Loads and increments act only on the pointer that is selected.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            primary_data_pointer   <= `POINTER_RESET;
            secondary_data_pointer <= `POINTER_RESET;
        end else if (primary_data_pointer_we || primary_data_pointer_inc) begin
            if (pointer_select[0]) begin
                secondary_data_pointer <= primary_data_pointer_we ? primary_data_pointer_wdata : secondary_data_pointer + 16'h0001;
            end else begin
                primary_data_pointer <= primary_data_pointer_we ? primary_data_pointer_wdata : primary_data_pointer + 16'h0001;
            end
        end
    end

    // Sequencer: one fetch machine cycle, then (stretch + 1) access cycles.
    // The stretch value is latched at start so a mid-move write cannot corrupt timing.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state        <= ST_IDLE;
            phase        <= 2'h0;
            stretch_seen <= 3'h0;
            dir_write    <= 1'b0;
            move_done    <= 1'b0;
            cpu_hold     <= 1'b0;
        end else begin
            move_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req.start) begin
                        state        <= ST_FETCH;
                        phase        <= 2'h0;
                        stretch_seen <= stretch_select;
                        dir_write    <= req.is_write;
                        cpu_hold     <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h3) begin
                        state <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h3) begin
                        if (stretch_seen == 3'h0) begin
                            state     <= ST_IDLE;
                            move_done <= 1'b1;
                            cpu_hold  <= 1'b0;
                        end else begin
                            stretch_seen <= stretch_seen - 3'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Strobe counter: loaded at the end of the fetch, so the strobe starts with the access cycle.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            strobe_left <= 5'h00;
        end else if (state == ST_FETCH && phase == 2'h3) begin
            strobe_left <= next_strobe_len;
        end else if (strobe_left != 5'h00) begin
            strobe_left <= strobe_left - 5'h01;
        end
    end

    // External bus; strobes are registered from the counter so both are glitch free.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_bus <= '{addr: 16'h0000, data_out: 8'h00, data_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
        end else begin
            ext_bus.addr     <= (state == ST_IDLE) ? ext_bus.addr : sel_pointer;
            ext_bus.data_out <= (state == ST_IDLE && req.start) ? req.write_data : ext_bus.data_out;
            // Write data is driven from the strobe's falling edge to the end of the access cycles.
            ext_bus.data_oe  <= dir_write && ((state == ST_FETCH && phase == 2'h3) ||
                                (state == ST_ACCESS && !(phase == 2'h3 && stretch_seen == 3'h0)));
            if ((state == ST_FETCH && phase == 2'h3) || strobe_left > 5'h01) begin
                ext_bus.rd_n <= dir_write;
                ext_bus.wr_n <= !dir_write;
            end else begin
                ext_bus.rd_n <= 1'b1;
                ext_bus.wr_n <= 1'b1;
            end
        end
    end

    // Read data is captured on the last strobe clock, before the strobe rises.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            read_data <= 8'h00;
        end else if (!dir_write && strobe_left == 5'h01) begin
            read_data <= ext_data_in;
        end
    end

    // Strobe width counted against the stretch value latched for the move.
    logic [4:0] low_count;
    logic [4:0] width_seen;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            low_count  <= 5'h00;
            width_seen <= 5'h00;
        end else begin
            low_count <= (!ext_bus.rd_n || !ext_bus.wr_n) ? low_count + 5'h01 : 5'h00;
            if (state == ST_IDLE && req.start) begin
                width_seen <= (stretch_select == 3'h0) ? `STROBE_BASE_ZERO : {stretch_select, 2'b00};
            end
        end
    end

    strobe_width_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(ext_bus.rd_n & ext_bus.wr_n) |-> low_count == width_seen)
        else $error("Strobe width differs from stretch setting.");

    fetch_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == ST_IDLE && req.start) |=> (state == ST_FETCH) [*4] ##1 (state == ST_ACCESS))
        else $error("Opcode fetch did not last four clocks.");

    no_strobe_fetch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == ST_FETCH) |-> (ext_bus.rd_n && ext_bus.wr_n))
        else $error("Strobe active during opcode fetch.");

    fast_move_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == ST_IDLE && req.start && stretch_select == 3'h0) |-> ##9 move_done)
        else $error("Stretch zero move not two machine cycles.");

    default_move_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == ST_IDLE && req.start && stretch_select == 3'h1) |-> ##13 move_done)
        else $error("Stretch one move not three machine cycles.");

    hold_during_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state != ST_IDLE) |-> cpu_hold)
        else $error("CPU not held during external data move.");

    idle_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        move_done |-> !cpu_hold && state == ST_IDLE)
        else $error("Hold not released after move.");

    pointer_inc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (primary_data_pointer_inc && !primary_data_pointer_we && pointer_select[0]) |=>
        secondary_data_pointer == $past(secondary_data_pointer) + 16'h0001 &&
        $stable(primary_data_pointer))
        else $error("Increment did not act on selected pointer.");

    strobe_dir_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ext_bus.wr_n |-> dir_write && ext_bus.rd_n)
        else $error("Write strobe during a read move.");

    write_data_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ext_bus.wr_n |-> ext_bus.data_oe)
        else $error("Write strobe low without write data driven.");

    stretch_field_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_we |=> stretch_select == $past(ctrl_wdata[2:0]))
        else $error("Stretch field not taken from bits 2-0.");
endmodule : external_data_access_stretch

// ---- xmove_defs.svh ----
// Timing constants and reset values for the external data move sequencer.
`ifndef XMOVE_DEFS_SVH
`define XMOVE_DEFS_SVH
`define CLKS_PER_MC       3'h4
`define STRETCH_RESET     3'h1
`define STRETCH_LSB       0
`define STRETCH_MSB       2
`define POINTER_SEL_RESET 8'h00
`define POINTER_RESET     16'h0000
`define STROBE_BASE_ZERO  5'h02
`define CLOCK_PERIOD_NS   40
`endif

// ---- xmove_pkg.sv ----
// Types shared by the external data move sequencer.
package xmove_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FETCH  = 2'b01,
        ST_ACCESS = 2'b10
    } move_state_t;

    typedef struct packed {
        logic        start;
        logic        is_write;
        logic [7:0]  write_data;
    } move_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data_out;
        logic        data_oe;
        logic        rd_n;
        logic        wr_n;
    } ext_bus_t;
endpackage : xmove_pkg

// ---- ext_mem_model.sv ----
// Behavioural external data memory that answers the sequencer's strobes.
`timescale 1ns/10ps
module ext_mem_model (
    // Clock.
    input  wire logic                clk_sys,
    // Bus from the sequencer.
    input  wire xmove_pkg::ext_bus_t ext_bus,
    // Read data back to the sequencer.
    output logic [7:0]               ext_data_in
);
    import xmove_pkg::*;
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h00;

    // Writes land on every clock that the write strobe is low.
    always @(posedge clk_sys) begin
        if (!ext_bus.wr_n && ext_bus.data_oe) begin
            mem[ext_bus.addr[7:0]] <= ext_bus.data_out;
        end
        if (!ext_bus.rd_n) begin
            last <= ext_data_in;
        end
    end

    // A released bus shows the inverse of the last byte, so a late capture is caught.
    assign ext_data_in = !ext_bus.rd_n ? mem[ext_bus.addr[7:0]] : ~last;
endmodule : ext_mem_model

// ---- external_data_access_stretch_tb.sv ----
// Self-checking bench for the external data move sequencer.
`timescale 1ns/10ps
module external_data_access_stretch_tb;
    import xmove_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    move_req_t   req = '0;
    logic        ctrl_we = 1'b0, psel_we = 1'b0, primary_data_pointer_we = 1'b0, primary_data_pointer_inc = 1'b0, cpu_hold, move_done;
    logic [7:0]  ctrl_wdata = 8'h00, psel_wdata = 8'h00, ext_data_in, read_data, clock_control_reg, pointer_select;
    logic [15:0] primary_data_pointer_wdata = 16'h0000, primary_data_pointer, secondary_data_pointer;
    ext_bus_t    ext_bus;
    int          fail_count = 0, cmp_count = 0;

    // Half period of 20 ns gives the 25 MHz core clock.
    always #20 clk_sys = ~clk_sys;

    external_data_access_stretch dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .ctrl_we(ctrl_we),
        .ctrl_wdata(ctrl_wdata), .psel_we(psel_we), .psel_wdata(psel_wdata), .primary_data_pointer_we(primary_data_pointer_we),
        .primary_data_pointer_wdata(primary_data_pointer_wdata), .primary_data_pointer_inc(primary_data_pointer_inc), .ext_data_in(ext_data_in), .cpu_hold(cpu_hold),
        .move_done(move_done), .read_data(read_data), .clock_control_reg(clock_control_reg),
        .pointer_select(pointer_select), .primary_data_pointer(primary_data_pointer),
        .secondary_data_pointer(secondary_data_pointer), .ext_bus(ext_bus));
    ext_mem_model mem (.clk_sys(clk_sys), .ext_bus(ext_bus), .ext_data_in(ext_data_in));

    // Compares one value and counts it.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // Pulses one control write: 0 stretch, 1 pointer select, 2 pointer load, 3 pointer increment.
    task automatic poke_reg(input int k, input logic [15:0] v);
        @(posedge clk_sys);
        ctrl_we    <= (k == 0);
        psel_we    <= (k == 1);
        primary_data_pointer_we    <= (k == 2);
        primary_data_pointer_inc   <= (k == 3);
        ctrl_wdata <= v[7:0];
        psel_wdata <= v[7:0];
        primary_data_pointer_wdata <= v;
        @(posedge clk_sys);
        {ctrl_we, psel_we, primary_data_pointer_we, primary_data_pointer_inc} <= 4'h0;
    endtask : poke_reg

    // Runs one move and judges its length, strobe and address; a poke retries start and stretch mid-move.
    task automatic do_move(input logic w, input logic [7:0] d, input logic [2:0] s, input logic [15:0] a,
                           input logic poke);
        int t, first, width, other;
        logic [15:0] seen_addr;
        t = 0;
        first = 0;
        width = 0;
        other = 0;
        seen_addr = 16'h0000;
        @(posedge clk_sys);
        req <= '{start: 1'b1, is_write: w, write_data: d};
        @(posedge clk_sys);
        req.start <= 1'b0;
        for (int k = 1; k < 60 && t == 0; k++) begin
            @(posedge clk_sys);
            req.start  <= poke && (k == 2);
            ctrl_we    <= poke && (k == 2);
            ctrl_wdata <= 8'h07;
            #1;
            if (k == 1) chk(16'(cpu_hold), 16'h0001);
            if ((w ? ext_bus.wr_n : ext_bus.rd_n) === 1'b0) begin
                width++;
                if (first == 0) seen_addr = ext_bus.addr;
                if (first == 0) first = k;
            end
            if ((w ? ext_bus.rd_n : ext_bus.wr_n) === 1'b0) other++;
            if (move_done === 1'b1) t = k;
        end
        chk(16'(t), 16'(4 * (s + 2)));
        chk(16'(first), 16'h0004);
        chk(seen_addr, a);
        chk(16'(width), 16'((s == 3'h0) ? 2 : 4 * s));
        chk(16'(other), 16'h0000);
        if (!w) chk(16'(read_data), 16'(d));
        // A refused start must leave the sequencer idle after the pulse.
        @(posedge clk_sys);
        #1;
        chk(16'(cpu_hold), 16'h0000);
        $display("move finished write %0d stretch %0d poke %0d", w, s, poke);
    endtask : do_move

    // Reset state, then a default-length write and a read refused a second start.
    task automatic check_reset;
        @(negedge clk_sys);
        chk(16'({clock_control_reg[2:0], pointer_select, cpu_hold, move_done, ext_bus.rd_n, ext_bus.wr_n}),
            16'h1003);
        chk(primary_data_pointer | secondary_data_pointer, 16'h0000);
        do_move(1'b1, 8'ha5, 3'h1, 16'h0000, 1'b0); // Default stretch of one.
        do_move(1'b0, 8'ha5, 3'h1, 16'h0000, 1'b1); // Busy start ignored; stretch write lands but this move keeps stretch one.
        chk(16'(clock_control_reg[2:0]), 16'h0007);
        $display("reset test done");
    endtask : check_reset

    // Loads both pointers and steps the selected one.
    task automatic check_pointers;
        poke_reg(2, 16'h1234);
        poke_reg(1, 16'h0001);
        poke_reg(2, 16'h0040);
        poke_reg(3, 16'h0000);
        @(negedge clk_sys);
        chk(primary_data_pointer, 16'h1234);
        chk(secondary_data_pointer, 16'h0041);
        $display("pointer test done");
    endtask : check_pointers

    // Every stretch code, alternating pointers, write then read back.
    task automatic sweep_stretch;
        for (int s = 0; s < 8; s++) begin
            poke_reg(0, 16'(s));
            poke_reg(1, 16'(s % 2));
            do_move(1'b1, 8'h3c ^ 8'(s), 3'(s), (s % 2) ? 16'h0041 : 16'h1234, 1'b0);
            do_move(1'b0, 8'h3c ^ 8'(s), 3'(s), (s % 2) ? 16'h0041 : 16'h1234, 1'b0);
        end
        $display("stretch sweep done");
    endtask : sweep_stretch

    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check_reset();
        check_pointers();
        sweep_stretch();
        report_and_stop();
    end

    // About 500 cycles are needed; twenty times that is allowed before the run is cut.
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
endmodule : external_data_access_stretch_tb
